// [rtl/sdb_pkg.sv]
// Constants for the stereo decode and blend control block.
// Assumes a 32-bit classic Wishbone slave port and a 20 MHz clock.
package sdb_pkg;
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] ADR_STATUS = 8'h04;
    localparam logic [ADR_W-1:0] ADR_METRICS = 8'h08;
    localparam logic [ADR_W-1:0] ADR_MBASE = 8'h10;
    localparam logic [ADR_W-1:0] ADR_MLAST = 8'h3C;
    localparam int MSTRIDE_SH = 4;
    localparam logic [1:0] FLD_STEREO = 2'h0;
    localparam logic [1:0] FLD_MONO = 2'h1;
    localparam logic [1:0] FLD_ATTACK = 2'h2;
    localparam logic [1:0] FLD_RELEASE = 2'h3;
    localparam int N_METRIC = 3;
    localparam int MET_RSSI = 0;
    localparam int MET_SNR = 1;
    localparam int MET_MPATH = 2;
    localparam logic [7:0] RST_STEREO = 8'h28;
    localparam logic [7:0] RST_MONO = 8'h14;
    localparam logic [7:0] RST_ATTACK = 8'h10;
    localparam logic [7:0] RST_RELEASE = 8'h04;
    localparam int SEP_W = 9;
    localparam logic [SEP_W-1:0] SEP_UNITY = 9'h100;
    localparam int ST_SEP_LSB = 0;
    localparam int ST_STEREO_BIT = 9;
    localparam int ST_MONO_BIT = 10;
    localparam int ST_RULER_LSB = 12;
    localparam int STEP_TIME_NS = 1000000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
endpackage

// [rtl/sdb_metric_target.sv]
// Target separation factor derived from one quality metric.
// Assumes a metric where a higher value means a better signal.
`timescale 1ns/1ns
module sdb_metric_target #(
    parameter int MW = 8
) (
    input wire logic [MW-1:0] metric_i,
    input wire logic [MW-1:0] thr_stereo_i,
    input wire logic [MW-1:0] thr_mono_i,
    output logic [sdb_pkg::SEP_W-1:0] target_o,
    output logic below_mono_o,
    output logic above_stereo_o
);
    import sdb_pkg::*;
    logic [MW-1:0] span;
    logic [MW-1:0] pos;
    logic [MW+SEP_W-1:0] scaled;
    always_comb begin
        span = thr_stereo_i - thr_mono_i;
        pos = metric_i - thr_mono_i;
        scaled = ({{SEP_W{1'b0}}, pos} << (SEP_W - 1)) / {{SEP_W{1'b0}}, span};
        below_mono_o = metric_i < thr_mono_i;
        above_stereo_o = metric_i >= thr_stereo_i;
        if (below_mono_o) begin
            target_o = '0;
        end else if (above_stereo_o || span == '0) begin
            target_o = SEP_UNITY;
        end else begin
            target_o = scaled[SEP_W-1:0];
        end
    end
endmodule

// [rtl/sdb_blend.sv]
// Stereo matrix decoder with adaptive stereo-to-mono blending.
// Assumes synchronous audio samples and metrics, Wishbone master.
`timescale 1ns/1ns
module sdb_blend #(
    parameter int AW = 16,
    parameter int MW = 8,
    parameter int STEP_DIV = sdb_pkg::STEP_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sdb_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic in_valid_i,
    input wire logic signed [AW-1:0] sum_i,
    input wire logic signed [AW-1:0] sub_i,
    input wire logic signed [AW-1:0] pilot_i_i,
    input wire logic signed [AW-1:0] pilot_q_i,
    input wire logic [MW-1:0] rssi_i,
    input wire logic [MW-1:0] snr_i,
    input wire logic [MW-1:0] multipath_i,
    output logic out_valid_o,
    output logic signed [AW:0] left_o,
    output logic signed [AW:0] right_o,
    output logic [sdb_pkg::SEP_W-1:0] sep_o
);
    import sdb_pkg::*;

    // Register file
    logic [MW-1:0] thr_st [N_METRIC];
    logic [MW-1:0] thr_mn [N_METRIC];
    logic [7:0] atk [N_METRIC];
    logic [7:0] rel [N_METRIC];
    logic [MW-1:0] next_thr_st [N_METRIC];
    logic [MW-1:0] next_thr_mn [N_METRIC];
    logic [7:0] next_atk [N_METRIC];
    logic [7:0] next_rel [N_METRIC];
    logic [31:0] next_wb_dat;
    logic next_wb_ack;
    logic wr_fire;
    logic mreg_hit;
    logic [1:0] midx;
    logic [31:0] status_word;
    logic [31:0] metrics_word;

    // Metric evaluation
    logic [MW-1:0] metric [N_METRIC];
    logic [SEP_W-1:0] target [N_METRIC];
    logic below [N_METRIC];
    logic above [N_METRIC];
    logic [SEP_W-1:0] min_target;
    logic [1:0] ruler;
    logic any_mono;
    logic all_stereo;

    // Blend slew
    logic [SEP_W-1:0] sep;
    logic [SEP_W-1:0] next_sep;
    logic [1:0] ruler_q;
    logic [1:0] next_ruler_q;
    logic [$clog2(STEP_DIV)-1:0] step_cnt;
    logic [$clog2(STEP_DIV)-1:0] next_step_cnt;
    logic step_en;
    logic [SEP_W:0] sep_up;
    logic [SEP_W:0] sep_dn;

    // Audio pipeline
    logic signed [AW-1:0] s1_sum;
    logic signed [AW-1:0] s1_sub;
    logic signed [AW-1:0] s1_ref;
    logic s1_valid;
    logic signed [AW-1:0] next_s1_sum;
    logic signed [AW-1:0] next_s1_sub;
    logic signed [AW-1:0] next_s1_ref;
    logic signed [2*AW:0] pil_sq;
    logic signed [2*AW-1:0] demod;
    logic signed [AW-1:0] diff;
    logic signed [AW+SEP_W:0] diff_sc;
    logic signed [AW-1:0] diff_bl;
    logic signed [AW:0] next_left;
    logic signed [AW:0] next_right;

    assign metric[MET_RSSI] = rssi_i;
    assign metric[MET_SNR] = snr_i;
    assign metric[MET_MPATH] = multipath_i;

    genvar g;
    generate
        for (g = 0; g < N_METRIC; g++) begin : g_met
            sdb_metric_target #(
                .MW(MW)
            ) u_tgt (
                .metric_i(metric[g]),
                .thr_stereo_i(thr_st[g]),
                .thr_mono_i(thr_mn[g]),
                .target_o(target[g]),
                .below_mono_o(below[g]),
                .above_stereo_o(above[g])
            );
        end
    endgenerate

    always_comb begin
        min_target = target[0];
        ruler = 2'h0;
        any_mono = 1'b0;
        all_stereo = 1'b1;
        for (int i = 0; i < N_METRIC; i++) begin
            if (target[i] < min_target) begin
                min_target = target[i];
                ruler = 2'(i);
            end
            any_mono = any_mono | below[i];
            all_stereo = all_stereo & above[i];
        end
    end

    // Wishbone slave: ack one cycle after the request, writes land on
    // the edge where the master sees ack.
    always_comb begin
        wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
        mreg_hit = wb_adr_i >= ADR_MBASE && wb_adr_i <= ADR_MLAST;
        midx = 2'(wb_adr_i >> MSTRIDE_SH) - 2'h1;
        status_word = '0;
        status_word[ST_SEP_LSB +: SEP_W] = sep;
        status_word[ST_STEREO_BIT] = sep == SEP_UNITY;
        status_word[ST_MONO_BIT] = sep == '0;
        status_word[ST_RULER_LSB +: 2] = ruler_q;
        metrics_word = {8'h00, 8'(multipath_i), 8'(snr_i), 8'(rssi_i)};
        next_wb_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_wb_dat = '0;
        if (next_wb_ack && !wb_we_i) begin
            if (wb_adr_i == ADR_STATUS) begin
                next_wb_dat = status_word;
            end else if (wb_adr_i == ADR_METRICS) begin
                next_wb_dat = metrics_word;
            end else if (mreg_hit) begin
                unique case (wb_adr_i[3:2])
                    FLD_STEREO: next_wb_dat = 32'(thr_st[midx]);
                    FLD_MONO: next_wb_dat = 32'(thr_mn[midx]);
                    FLD_ATTACK: next_wb_dat = 32'(atk[midx]);
                    FLD_RELEASE: next_wb_dat = 32'(rel[midx]);
                endcase
            end
        end
        for (int i = 0; i < N_METRIC; i++) begin
            next_thr_st[i] = thr_st[i];
            next_thr_mn[i] = thr_mn[i];
            next_atk[i] = atk[i];
            next_rel[i] = rel[i];
        end
        if (wr_fire && mreg_hit && wb_sel_i[0]) begin
            unique case (wb_adr_i[3:2])
                FLD_STEREO: next_thr_st[midx] = MW'(wb_dat_i);
                FLD_MONO: next_thr_mn[midx] = MW'(wb_dat_i);
                FLD_ATTACK: next_atk[midx] = wb_dat_i[7:0];
                FLD_RELEASE: next_rel[midx] = wb_dat_i[7:0];
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            for (int i = 0; i < N_METRIC; i++) begin
                thr_st[i] <= RST_STEREO[MW-1:0];
                thr_mn[i] <= RST_MONO[MW-1:0];
                atk[i] <= RST_ATTACK;
                rel[i] <= RST_RELEASE;
            end
        end else begin
            wb_ack_o <= next_wb_ack;
            wb_dat_o <= next_wb_dat;
            thr_st <= next_thr_st;
            thr_mn <= next_thr_mn;
            atk <= next_atk;
            rel <= next_rel;
        end
    end

    // Slew the separation toward the poorest metric's target. A rate of
    // zero means jump at once; small rates trade reaction for smoothness.
    always_comb begin
        step_en = step_cnt == '0;
        next_step_cnt = step_en ? ($clog2(STEP_DIV))'(STEP_DIV - 1)
                                : step_cnt - 1'b1;
        next_ruler_q = ruler;
        sep_dn = {1'b0, sep} - {1'b0, atk[ruler]};
        sep_up = {1'b0, sep} + {1'b0, rel[ruler]};
        next_sep = sep;
        if (step_en) begin
            if (min_target < sep) begin
                if (atk[ruler] == 8'h00 || sep_dn[SEP_W] ||
                    sep_dn[SEP_W-1:0] < min_target) begin
                    next_sep = min_target;
                end else begin
                    next_sep = sep_dn[SEP_W-1:0];
                end
            end else if (min_target > sep) begin
                if (rel[ruler] == 8'h00 ||
                    sep_up > {1'b0, min_target}) begin
                    next_sep = min_target;
                end else begin
                    next_sep = sep_up[SEP_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sep <= '0;
            ruler_q <= 2'h0;
            step_cnt <= '0;
        end else begin
            sep <= next_sep;
            ruler_q <= next_ruler_q;
            step_cnt <= next_step_cnt;
        end
    end

    // Audio: stage one forms cos(2wt) from the quadrature pilot, stage
    // two demodulates and runs the matrix. The sub-carrier image of the
    // product is left for the downstream audio filter.
    always_comb begin
        pil_sq = (2*AW+1)'(pilot_i_i * pilot_i_i) -
                 (2*AW+1)'(pilot_q_i * pilot_q_i);
        next_s1_ref = s1_ref;
        next_s1_sum = s1_sum;
        next_s1_sub = s1_sub;
        if (in_valid_i) begin
            next_s1_ref = pil_sq[2*AW-2 -: AW];
            next_s1_sum = sum_i;
            next_s1_sub = sub_i;
        end
        demod = s1_sub * s1_ref;
        diff = demod[2*AW-2 -: AW];
        diff_sc = diff * $signed({1'b0, sep});
        diff_bl = diff_sc[AW+SEP_W-2 -: AW];
        next_left = (AW+1)'(s1_sum) + (AW+1)'(diff_bl);
        next_right = (AW+1)'(s1_sum) - (AW+1)'(diff_bl);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_valid <= 1'b0;
            s1_ref <= '0;
            s1_sum <= '0;
            s1_sub <= '0;
            out_valid_o <= 1'b0;
            left_o <= '0;
            right_o <= '0;
            sep_o <= '0;
        end else begin
            s1_valid <= in_valid_i;
            s1_ref <= next_s1_ref;
            s1_sum <= next_s1_sum;
            s1_sub <= next_s1_sub;
            out_valid_o <= s1_valid;
            if (s1_valid) begin
                left_o <= next_left;
                right_o <= next_right;
            end
            sep_o <= next_sep;
        end
    end
endmodule

// [tb/sdb_blend_props.sv]
// Checker for the stereo decode and blend block ports.
// Assumes binding to sdb_blend with its parameter values.
`timescale 1ns/1ns
module sdb_blend_props
    import sdb_pkg::*;
#(
    parameter int AW = 16,
    parameter int STEP_DIV = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic in_valid_i,
    input wire logic signed [AW-1:0] sum_i,
    input wire logic out_valid_o,
    input wire logic signed [AW:0] left_o,
    input wire logic signed [AW:0] right_o,
    input wire logic [sdb_pkg::SEP_W-1:0] sep_o
);
    int gap;
    int next_gap;
    logic [SEP_W-1:0] sep_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Saturates so the first step after reset is not flagged
    always_comb begin
        next_gap = (gap >= STEP_DIV) ? STEP_DIV : gap + 1;
        if (sep_o != sep_q) begin
            next_gap = 0;
        end
    end
    always_ff @(posedge clk_i) begin
        gap <= rst_i ? STEP_DIV : next_gap;
        sep_q <= rst_i ? '0 : sep_o;
    end
    ack_lat_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    idle_dat_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    out_lat_a: assert property (in_valid_i |-> ##2 out_valid_o)
        else $error("sample output late");
    out_cause_a: assert property (out_valid_o |-> $past(in_valid_i, 2))
        else $error("output without sample");
    sep_range_a: assert property (sep_o <= SEP_UNITY)
        else $error("separation above unity");
    mono_out_a: assert property (out_valid_o && sep_o == 0 && sep_q == 0
        |-> left_o == $past(sum_i, 2) && right_o == left_o)
        else $error("mono output not sum");
    step_gap_a: assert property (sep_o != sep_q |-> gap >= STEP_DIV - 1)
        else $error("blend stepped too soon");
    cover property (out_valid_o && sep_o == 0);
    cover property (out_valid_o && sep_o == SEP_UNITY);
    cover property (wb_ack_o && sep_o != sep_q);
endmodule

// [tb/sdb_host.sv]
// Host model: classic Wishbone master doing register accesses.
// Assumes a single clock shared with the slave.
`timescale 1ns/1ns
module sdb_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    int n_to = 0;
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    // Request held until ack is sampled; status reads serve the query
    task xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
              input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_i !== 1'b1 && i < 50);
        q = dat_i;
        n_to += (i >= 50);
        {cyc_o, stb_o} <= 2'b00;
    endtask
endmodule

// [tb/testbench.sv]
// Testbench for the stereo decode and blend block.
// Assumes the host model and the checker bound below.
`timescale 1ns/1ns
module testbench;
    import sdb_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc, stb, we, ack, ov;
    logic iv = 0;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rdat;
    logic signed [15:0] sum = 0, sub = 0, pi = 0, pq = 0;
    logic [7:0] met [3] = '{8'h0, 8'h0, 8'h0};
    logic signed [16:0] lf, rt;
    logic [8:0] sep;
    int n_fail = 0;
    int n_checks = 0;
    initial forever #25 clk_i = ~clk_i;
    sdb_host u_sdb_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wd));
    sdb_blend #(.STEP_DIV(8)) u_sdb_blend (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .in_valid_i(iv), .sum_i(sum), .sub_i(sub), .pilot_i_i(pi),
        .pilot_q_i(pq), .rssi_i(met[0]), .snr_i(met[1]),
        .multipath_i(met[2]), .out_valid_o(ov), .left_o(lf), .right_o(rt),
        .sep_o(sep));
    task end_of_test;
        n_fail += u_sdb_host.n_to;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_sdb_host.xfer(1'b0, a, 4'hF, 32'h0, q);
        if (u_sdb_host.n_to != 0) end_of_test;
        chk(q, e);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_sdb_host.xfer(1'b1, a, 4'h1, d, q);
        if (u_sdb_host.n_to != 0) end_of_test;
    endtask
    task setm(input logic [7:0] r, input logic [7:0] s, input logic [7:0] m);
        @(posedge clk_i);
        met <= '{r, s, m};
    endtask
    task wait_sep(input logic [8:0] e, input int chg);
        logic [8:0] o;
        int i;
        o = sep;
        for (i = 0; i < 900 && (chg ? sep === o : sep !== e); i++)
            @(posedge clk_i);
        chk({23'h0, sep}, {23'h0, e});
        if (i >= 900) begin
            n_fail++;
            end_of_test;
        end
    endtask
    task smp(input logic signed [15:0] s, d, i, q);
        int n;
        @(posedge clk_i);
        {iv, sum, sub, pi, pq} <= {1'b1, s, d, i, q};
        @(posedge clk_i);
        iv <= 1'b0;
        for (n = 0; n < 4 && ov !== 1'b1; n++) @(posedge clk_i);
        chk({31'h0, ov}, 32'h1);
    endtask
    initial begin
        logic [7:0] b;
        logic [31:0] q;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            b = 8'((k + 1) << 4);
            rchk(b, 32'(RST_STEREO));
            rchk(b + 8'h4, 32'(RST_MONO));
            rchk(b + 8'h8, 32'(RST_ATTACK));
            rchk(b + 8'hC, 32'(RST_RELEASE));
            wr(b, 32'h40);
            wr(b + 8'h4, 32'h20);
            wr(b + 8'h8, 32'h0);
            wr(b + 8'hC, 32'h0);
        end
        u_sdb_host.xfer(1'b1, 8'h10, 4'hE, 32'h55, q);
        rchk(8'h10, 32'h40);
        wr(8'h44, 32'h7);
        rchk(8'h44, 32'h0);
        setm(8'h11, 8'h22, 8'h33);
        rchk(ADR_METRICS, 32'h00332211);
        setm(8'h80, 8'h80, 8'h80);
        wait_sep(9'h100, 0);
        rchk(ADR_STATUS, 32'h300);
        smp(16'sh0100, 16'sh0400, 16'sh7FFF, 16'sh0);
        chk(32'(lf + rt), 32'h200);
        chk({31'h0, lf > rt}, 32'h1);
        smp(16'sh0100, 16'sh0400, 16'sh5A82, 16'sh5A82);
        chk(32'(lf - rt), 32'h0);
        for (int k = 0; k < 3; k++) begin
            setm(k == 0 ? 8'h10 : 8'h80, k == 1 ? 8'h10 : 8'h80,
                 k == 2 ? 8'h10 : 8'h80);
            wait_sep(9'h0, 0);
            rchk(ADR_STATUS, 32'h400 | 32'(k << 12));
            smp(16'sh1234, 16'sh0800, 16'sh7FFF, 16'sh0);
            chk(32'(lf), 32'h1234);
            chk(32'(rt), 32'h1234);
        end
        setm(8'h30, 8'h80, 8'h80);
        wait_sep(9'h080, 0);
        setm(8'h80, 8'h80, 8'h28);
        wait_sep(9'h040, 0);
        rchk(ADR_STATUS, 32'h2040);
        wr(8'h28, 32'h10);
        wr(8'h2C, 32'h08);
        rchk(8'h28, 32'h10);
        setm(8'h80, 8'h80, 8'h80);
        wait_sep(9'h100, 0);
        setm(8'h80, 8'h10, 8'h80);
        wait_sep(9'h0F0, 1);
        wait_sep(9'h0, 0);
        setm(8'h80, 8'h30, 8'h80);
        wait_sep(9'h008, 1);
        wait_sep(9'h080, 0);
        end_of_test;
    end
endmodule
bind sdb_blend sdb_blend_props #(.AW(AW), .STEP_DIV(STEP_DIV)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_valid_i(in_valid_i),
    .sum_i(sum_i), .out_valid_o(out_valid_o), .left_o(left_o),
    .right_o(right_o), .sep_o(sep_o));
